// [dv/dts_core_properties.sv]
// Concurrent checks on the ports of the trip and diagnostic block
`default_nettype none
module dts_core_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic cold_monitor_in_n,
  input wire logic hot_monitor_in_n,
  input wire logic excess_current_monitor_in_n,
  input wire logic excess_voltage_monitor_in_n,
  input wire logic excess_speed_monitor_in_n,
  input wire logic power_module_fault,
  input wire logic drive_start_request,
  input wire logic supply_rail_low,
  input wire logic self_test_warning,
  input wire logic self_test_fault,
  input wire logic fault_log_pulse,
  input wire logic restart_pulse,
  input wire logic nvm_write_block
);
  logic [5:0] act;
  logic [2:0] cnt [6];
  logic rd_trip;
  logic rd_diag;
  assign act = {power_module_fault, ~cold_monitor_in_n, ~hot_monitor_in_n,
    ~excess_current_monitor_in_n, ~excess_voltage_monitor_in_n, ~excess_speed_monitor_in_n};
  assign rd_trip = psel && !penable && !pwrite && paddr == {dts_pkg::IDX_TRIP[13:0], 2'b00};
  assign rd_diag = psel && !penable && !pwrite && paddr == {dts_pkg::IDX_DIAG[13:0], 2'b00};
  // ==========================================================
  // Cycles each trip source has been active, saturating at four
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 6; i++) begin
      if (!presetn)
        cnt[i] <= 3'h0;
      else if (!act[i])
        cnt[i] <= 3'h0;
      else if (cnt[i] != 3'h4)
        cnt[i] <= cnt[i] + 3'h1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  for (genvar i = 0; i < 6; i++) begin : g_src
    chk_trip_latch: assert property (rd_trip && cnt[i] == 3'h4 |=> prdata[i])
      else $error("trip bit clear while its source is active");
  end
  chk_trip_reserved: assert property (rd_trip |=> prdata[31:6] == 26'h0)
    else $error("reserved trip bits not zero");
  chk_diag_reserved: assert property (rd_diag |=> !prdata[15] && !prdata[12] && prdata[31:16] == 16'h0)
    else $error("reserved diagnostic bits not zero");
  chk_answer_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("answer not exactly one cycle after setup");
  chk_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("misaligned access not refused");
  chk_nvm_block_on: assert property (supply_rail_low [*4] |=> nvm_write_block)
    else $error("nvm writes not blocked on low supply");
  chk_nvm_block_off: assert property (!supply_rail_low [*4] |=> !nvm_write_block)
    else $error("nvm writes blocked on good supply");
  chk_wdog_restart: assert property (fault_log_pulse |-> ##[124:128] restart_pulse)
    else $error("no restart after watchdog hold");
  chk_log_pulse_one: assert property (fault_log_pulse |=> !fault_log_pulse [*8])
    else $error("fault log pulse repeated");
  chk_warn_sticky: assert property (self_test_warning |=> self_test_warning)
    else $error("self-test warning dropped");
  chk_fault_start: assert property ($rose(self_test_fault) |-> $past(drive_start_request, 3))
    else $error("self-test fault without start request");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the trip and diagnostic block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cold_monitor_in_n, hot_monitor_in_n, excess_current_monitor_in_n;
  logic excess_voltage_monitor_in_n, excess_speed_monitor_in_n, power_module_fault;
  logic inrush_bypass_missing, precharge_relay_open, precharge_relay_drive;
  logic drive_start_request, watchdog_timeout, supply_rail_low;
  logic self_test_warning, self_test_fault, fault_log_pulse, restart_pulse;
  logic nvm_write_block, irq;
  logic [33:0] expq [$];
  logic [33:0] x;
  logic [4:0] m;
  int num_errors = 0;
  int compares = 0;
  int n;
  dts_core dts_core_i (.*);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========================================================
  // Report
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic compare_rd(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic compare_pin(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // Drivers
  function automatic logic [15:0] adr(input logic [15:0] i);
    return {i[13:0], 2'b00};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (n = 0; n < lim && s !== 1'b1; n++) @(posedge pclk);
    if (n == lim) begin
      num_errors++;
      conclude();
    end
  endtask
  // Idle edge first so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expq.push_back({!w && !err, err, e});
    @(posedge pclk);
    penable <= 1'b1;
    // Release at the very edge that samples pready high
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic mon(input logic [4:0] v);
    {cold_monitor_in_n, hot_monitor_in_n, excess_current_monitor_in_n,
      excess_voltage_monitor_in_n, excess_speed_monitor_in_n} <= ~v;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    cyc(12);
    presetn <= 1'b1;
  endtask
  // Read data is compared only on reads expected to succeed; pslverr is checked on every transfer
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && expq.size() > 0) begin
      x = expq.pop_front();
      compare_rd({pslverr, x[33] ? prdata : 32'h0}, x[32:0]);
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, power_module_fault, inrush_bypass_missing} = '0;
    {precharge_relay_open, precharge_relay_drive, drive_start_request} = '0;
    {watchdog_timeout, supply_rail_low} = '0;
    mon(5'h0);
    presetn = 1'b0;
    void'($urandom(87));
    do_reset();
    apb(0, adr(dts_pkg::IDX_TRIP), 0, dts_pkg::TRIP_RST, 0);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, dts_pkg::DIAG_RST, 0);
    apb(0, adr(dts_pkg::IDX_IRQ_EN), 0, 0, 0);
    apb(0, adr(dts_pkg::IDX_CTRL), 0, 0, 0);
    apb(0, adr(16'h0010), 0, 0, 1);
    apb(0, adr(dts_pkg::IDX_TRIP) + 16'h2, 0, 0, 1);
    apb(1, adr(dts_pkg::IDX_TRIP), $urandom, 0, 0);
    apb(0, adr(dts_pkg::IDX_TRIP), 0, 0, 0);
    $display("test reset_map done");
    for (int i = 0; i < 6; i++) begin
      m = (i < 5) ? 5'h1 << i : 5'($urandom);
      mon(m);
      cyc(6);
      apb(0, adr(dts_pkg::IDX_TRIP), 0, {27'h0, m}, 0);
      apb(1, adr(dts_pkg::IDX_CTRL), 32'h1, 0, 0);
      apb(0, adr(dts_pkg::IDX_TRIP), 0, {27'h0, m}, 0);
      mon(5'h0);
      cyc(4);
      apb(0, adr(dts_pkg::IDX_TRIP), 0, {27'h0, m}, 0);
      apb(1, adr(dts_pkg::IDX_CTRL), 32'h1, 0, 0);
      apb(0, adr(dts_pkg::IDX_TRIP), 0, 0, 0);
    end
    power_module_fault <= 1'b1;
    cyc(6);
    apb(0, adr(dts_pkg::IDX_TRIP), 0, 32'h20, 0);
    power_module_fault <= 1'b0;
    apb(1, adr(dts_pkg::IDX_CTRL), 32'h1, 0, 0);
    apb(0, adr(dts_pkg::IDX_TRIP), 0, 32'h20, 0);
    $display("test trips done");
    apb(1, adr(dts_pkg::IDX_IRQ_CLR), 32'hf, 0, 0);
    mon(5'h2);
    cyc(6);
    compare_pin({31'h0, irq}, 0);
    apb(0, adr(dts_pkg::IDX_IRQ_STAT), 0, 32'h1, 0);
    apb(1, adr(dts_pkg::IDX_IRQ_EN), 32'h1, 0, 0);
    cyc(2);
    compare_pin({31'h0, irq}, 1);
    apb(0, adr(dts_pkg::IDX_IRQ_EN), 0, 32'h1, 0);
    mon(5'h0);
    apb(1, adr(dts_pkg::IDX_IRQ_CLR), 32'h1, 0, 0);
    cyc(2);
    compare_pin({31'h0, irq}, 0);
    $display("test irq done");
    supply_rail_low <= 1'b1;
    cyc(6);
    compare_pin({31'h0, nvm_write_block}, 1);
    apb(1, adr(dts_pkg::IDX_CTRL), 32'h2, 0, 0);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 32'h800, 0);
    supply_rail_low <= 1'b0;
    cyc(6);
    compare_pin({31'h0, nvm_write_block}, 0);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 32'h800, 0);
    apb(1, adr(dts_pkg::IDX_CTRL), 32'h2, 0, 0);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 0, 0);
    $display("test supply done");
    watchdog_timeout <= 1'b1;
    wait_hi(fault_log_pulse, 10);
    watchdog_timeout <= 1'b0;
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 32'h2000, 0);
    wait_hi(restart_pulse, 200);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 0, 0);
    apb(0, adr(dts_pkg::IDX_IRQ_STAT), 0, 32'hc, 0);
    $display("test watchdog done");
    precharge_relay_open <= 1'b1;
    cyc(6);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 32'h4000, 0);
    wait_hi(self_test_warning, 2000);
    compare_pin({31'h0, n + 9 >= 1250 && n + 9 <= 1256}, 1);
    compare_pin({31'h0, self_test_fault}, 0);
    drive_start_request <= 1'b1;
    precharge_relay_open <= 1'b0;
    cyc(6);
    compare_pin({31'h0, self_test_fault}, 1);
    apb(1, adr(dts_pkg::IDX_CTRL), 32'h3, 0, 0);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 32'h4000, 0);
    apb(0, adr(dts_pkg::IDX_STATUS), 0, 32'h3, 0);
    for (int v = 1; v >= 0; v--) begin
      precharge_relay_drive <= 1'(v);
      cyc(5);
      apb(0, adr(dts_pkg::IDX_DOUT), 0, 32'(v), 0);
    end
    $display("test inrush done");
    drive_start_request <= 1'b0;
    do_reset();
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 0, 0);
    inrush_bypass_missing <= 1'b1;
    cyc(6);
    apb(0, adr(dts_pkg::IDX_DIAG), 0, 32'h4000, 0);
    $display("test second_reset done");
    cyc(2);
    conclude();
  end
endmodule
bind dts_core dts_core_properties dts_core_properties_i (.*);
`default_nettype wire

// [rtl/dts_core.sv]
// Drive trip latch and diagnostic status block with APB register access
//
// How it works
// - A faulty power module report sets latched trip bit 5.
// - A low cold monitor sets trip bit 4, covering a cold drive or a dead sensor.
// - A low hot monitor sets trip bit 3.
// - A low excess-current monitor sets trip bit 2.
// - A low excess-voltage monitor sets trip bit 1.
// - A low excess-speed monitor sets trip bit 0.
// - A trip reset clears monitor trip bits 0-4 only where the monitor is high again.
// - Missing inrush bypass or an open relay sets diagnostic bit 14 and, after a delay, a warning.
// - The self-test fault is raised when that condition stops a requested start.
// - Diagnostic bit 14 stays set once raised and ignores every clear request.
// - The synchronised relay drive state is readable in a separate digital output register.
// - A watchdog timeout sets bit 13, logs a fault, then clears itself and restarts.
// - A low supply blocks non-volatile writes and sets clearable warning bit 11.
`default_nettype none
module dts_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dts_pkg::ADDR_W-1:0] paddr,
  input wire logic [dts_pkg::DATA_W-1:0] pwdata,
  output logic [dts_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trip monitors, active low
  input wire logic cold_monitor_in_n,
  input wire logic hot_monitor_in_n,
  input wire logic excess_current_monitor_in_n,
  input wire logic excess_voltage_monitor_in_n,
  input wire logic excess_speed_monitor_in_n,
  // Fault and condition inputs, active high
  input wire logic power_module_fault,
  input wire logic inrush_bypass_missing,
  input wire logic precharge_relay_open,
  input wire logic precharge_relay_drive,
  input wire logic drive_start_request,
  input wire logic watchdog_timeout,
  input wire logic supply_rail_low,
  // Status outputs
  output logic self_test_warning,
  output logic self_test_fault,
  output logic fault_log_pulse,
  output logic restart_pulse,
  output logic nvm_write_block,
  output logic irq
);
  // ==========================================================
  // Input synchronisation
  dts_mon_if mon ();
  logic [dts_pkg::N_SYNC-1:0] raw;
  logic [dts_pkg::N_SYNC-1:0] lv;

  always_comb begin
    raw = '0;
    raw[dts_pkg::SI_SPEED_N] = excess_speed_monitor_in_n;
    raw[dts_pkg::SI_VOLT_N] = excess_voltage_monitor_in_n;
    raw[dts_pkg::SI_CURR_N] = excess_current_monitor_in_n;
    raw[dts_pkg::SI_HOT_N] = hot_monitor_in_n;
    raw[dts_pkg::SI_COLD_N] = cold_monitor_in_n;
    raw[dts_pkg::SI_PWR] = power_module_fault;
    raw[dts_pkg::SI_BYPASS] = inrush_bypass_missing;
    raw[dts_pkg::SI_RELAY_OPEN] = precharge_relay_open;
    raw[dts_pkg::SI_RELAY_DRV] = precharge_relay_drive;
    raw[dts_pkg::SI_START] = drive_start_request;
    raw[dts_pkg::SI_WDOG] = watchdog_timeout;
    raw[dts_pkg::SI_LOWVCC] = supply_rail_low;
  end

  dts_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw(raw),
    .mon(mon.src)
  );

  assign lv = mon.level;

  // ==========================================================
  // Register decode
  typedef enum logic [3:0] {
    RS_NONE, RS_TRIP, RS_DIAG, RS_DOUT, RS_CTRL, RS_ISTAT, RS_ICLR, RS_IEN, RS_STAT
  } dts_sel_t;

  function automatic dts_sel_t dts_decode(input logic [dts_pkg::ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = {2'h0, a[15:2]};
    if (a[1:0] != 2'h0) return RS_NONE;
    if (idx == dts_pkg::IDX_TRIP) return RS_TRIP;
    if (idx == dts_pkg::IDX_DIAG) return RS_DIAG;
    if (idx == dts_pkg::IDX_DOUT) return RS_DOUT;
    if (idx == dts_pkg::IDX_CTRL) return RS_CTRL;
    if (idx == dts_pkg::IDX_IRQ_STAT) return RS_ISTAT;
    if (idx == dts_pkg::IDX_IRQ_CLR) return RS_ICLR;
    if (idx == dts_pkg::IDX_IRQ_EN) return RS_IEN;
    if (idx == dts_pkg::IDX_STATUS) return RS_STAT;
    return RS_NONE;
  endfunction

  dts_sel_t sel;
  logic setup;
  logic wr;
  logic trip_reset;
  logic warn_clear;
  logic [dts_pkg::N_IRQ-1:0] irq_clr;

  assign sel = dts_decode(paddr);
  assign setup = psel && !penable;
  // Write lands on the access edge only, when pready is high
  assign wr = psel && penable && pready && pwrite;
  assign trip_reset = wr && (sel == RS_CTRL) && pwdata[dts_pkg::CTRL_TRIP_RESET];
  assign warn_clear = wr && (sel == RS_CTRL) && pwdata[dts_pkg::CTRL_WARN_CLEAR];
  assign irq_clr = (wr && (sel == RS_ICLR)) ? pwdata[dts_pkg::N_IRQ-1:0] : '0;

  // ==========================================================
  // Latched trip bits
  logic [15:0] trip_r;
  logic [15:0] trip_nxt;
  logic [dts_pkg::N_MON-1:0] mon_low;

  // Monitor inputs sit at trip positions 0-4, one for one
  assign mon_low = ~lv[dts_pkg::N_MON-1:0];
  always_comb begin
    trip_nxt = trip_r & dts_pkg::TRIP_MASK;
    // Power module fault is not released by a trip reset
    trip_nxt[dts_pkg::TRIP_PWR] = trip_r[dts_pkg::TRIP_PWR] | lv[dts_pkg::SI_PWR];
    for (int i = 0; i < dts_pkg::N_MON; i++) begin
      // Set wins: a monitor still low keeps its bit through the reset
      trip_nxt[i] = mon_low[i] | (trip_r[i] & ~trip_reset);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_r <= dts_pkg::TRIP_RST;
    end else begin
      trip_r <= trip_nxt;
    end
  end

  // ==========================================================
  // Inrush bypass diagnostic
  logic inrush_r;
  logic inrush_cond;
  logic [dts_pkg::CNT_W-1:0] warn_cnt_r;
  logic warn_r;
  logic stfault_r;
  assign inrush_cond = lv[dts_pkg::SI_BYPASS] | lv[dts_pkg::SI_RELAY_OPEN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inrush_r <= 1'b0;
    end else if (inrush_cond) begin
      inrush_r <= 1'b1;
    end
  end
  // Warning follows inrush_r (diagnostic bit 14) after a settle delay, then holds until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_cnt_r <= '0;
      warn_r <= 1'b0;
    end else if (inrush_r && !warn_r) begin
      if (warn_cnt_r == dts_pkg::CNT_W'(dts_pkg::WARN_DELAY_CYC - 1)) begin
        warn_r <= 1'b1;
      end else begin
        warn_cnt_r <= warn_cnt_r + 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stfault_r <= 1'b0;
    end else if (inrush_r && lv[dts_pkg::SI_START]) begin
      stfault_r <= 1'b1;
    end
  end

  // ==========================================================
  // Watchdog timeout sequence
  dts_pkg::dts_wd_state_t wd_r;
  logic wd_prev_r;
  logic wd_rise;
  logic [dts_pkg::CNT_W-1:0] wd_cnt_r;
  logic wdog_bit_r;
  logic log_r;
  logic restart_r;
  assign wd_rise = lv[dts_pkg::SI_WDOG] && !wd_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_prev_r <= 1'b0;
    end else begin
      wd_prev_r <= lv[dts_pkg::SI_WDOG];
    end
  end
  // Timeouts arriving mid-sequence are folded into the one in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_r <= dts_pkg::WD_IDLE;
      wd_cnt_r <= '0;
      wdog_bit_r <= 1'b0;
      log_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      log_r <= 1'b0;
      restart_r <= 1'b0;
      unique case (wd_r)
        dts_pkg::WD_IDLE: begin
          if (wd_rise) begin
            wdog_bit_r <= 1'b1;
            log_r <= 1'b1;
            wd_r <= dts_pkg::WD_LOG;
          end
        end
        dts_pkg::WD_LOG: begin
          wd_cnt_r <= '0;
          wd_r <= dts_pkg::WD_HOLD;
        end
        dts_pkg::WD_HOLD: begin
          if (wd_cnt_r == dts_pkg::CNT_W'(dts_pkg::WDOG_HOLD_CYC - 1)) begin
            wd_r <= dts_pkg::WD_RESTART;
          end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
          end
        end
        dts_pkg::WD_RESTART: begin
          wdog_bit_r <= 1'b0;
          restart_r <= 1'b1;
          wd_r <= dts_pkg::WD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Low supply write block
  logic lowvcc_r;
  logic block_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowvcc_r <= 1'b0;
      block_r <= 1'b0;
    end else begin
      block_r <= lv[dts_pkg::SI_LOWVCC];
      lowvcc_r <= lv[dts_pkg::SI_LOWVCC] | (lowvcc_r & ~warn_clear);
    end
  end

  logic [15:0] diag;

  always_comb begin
    diag = dts_pkg::DIAG_RST;
    diag[dts_pkg::DIAG_INRUSH] = inrush_r;
    diag[dts_pkg::DIAG_WDOG] = wdog_bit_r;
    diag[dts_pkg::DIAG_LOWVCC] = lowvcc_r;
    diag = diag & dts_pkg::DIAG_MASK;
  end

  // ==========================================================
  // Interrupts
  logic [dts_pkg::N_IRQ-1:0] ev;
  logic [dts_pkg::N_IRQ-1:0] istat_r;
  logic [dts_pkg::N_IRQ-1:0] ien_r;
  logic irq_r;
  assign ev[dts_pkg::IRQ_TRIP] = |(trip_nxt & ~trip_r);
  assign ev[dts_pkg::IRQ_INRUSH] = inrush_cond && !inrush_r;
  assign ev[dts_pkg::IRQ_WDOG] = (wd_r == dts_pkg::WD_IDLE) && wd_rise;
  assign ev[dts_pkg::IRQ_LOWVCC] = lv[dts_pkg::SI_LOWVCC] && !lowvcc_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= dts_pkg::IRQ_RST;
      ien_r <= dts_pkg::IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      // New event beats a clear in the same cycle
      istat_r <= ev | (istat_r & ~irq_clr);
      if (wr && (sel == RS_IEN)) begin
        ien_r <= pwdata[dts_pkg::N_IRQ-1:0];
      end
      irq_r <= |(istat_r & ien_r);
    end
  end

  // ==========================================================
  // APB read path: one flopped answer per transfer, no wait states
  logic [15:0] rd;
  logic [15:0] st;
  always_comb begin
    st = '0;
    st[dts_pkg::ST_WARN] = warn_r;
    st[dts_pkg::ST_FAULT] = stfault_r;
    st[dts_pkg::ST_NVM_BLOCK] = block_r;
    rd = '0;
    unique case (sel)
      RS_TRIP: rd = trip_r;
      RS_DIAG: rd = diag;
      RS_DOUT: rd[dts_pkg::DOUT_RELAY] = lv[dts_pkg::SI_RELAY_DRV];
      RS_ISTAT: rd[dts_pkg::N_IRQ-1:0] = istat_r;
      RS_IEN: rd[dts_pkg::N_IRQ-1:0] = ien_r;
      RS_STAT: rd = st;
      RS_NONE, RS_CTRL, RS_ICLR: rd = '0;
    endcase
  end
  logic [dts_pkg::DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && (sel == RS_NONE);
      prdata_r <= (setup && !pwrite) ? {16'h0000, rd} : '0;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign self_test_warning = warn_r;
  assign self_test_fault = stfault_r;
  assign fault_log_pulse = log_r;
  assign restart_pulse = restart_r;
  assign nvm_write_block = block_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// [rtl/dts_mon_if.sv]
// Interface: synchronised monitor levels passed from the input synchroniser to the core
`default_nettype none
interface dts_mon_if;
  logic [dts_pkg::N_SYNC-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

// [rtl/dts_pkg.sv]
// Package: register map, field positions, reset values and timing for the trip/diagnostic block
`default_nettype none
package dts_pkg;
  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] IDX_TRIP = 16'h0063;
  localparam logic [15:0] IDX_DIAG = 16'h0066;
  localparam logic [15:0] IDX_DOUT = 16'h1ca1;
  localparam logic [15:0] IDX_CTRL = 16'h0070;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0071;
  localparam logic [15:0] IDX_IRQ_CLR = 16'h0072;
  localparam logic [15:0] IDX_IRQ_EN = 16'h0073;
  localparam logic [15:0] IDX_STATUS = 16'h0074;
  // ==========================================================
  // Latched trip register fields
  localparam int TRIP_SPEED = 0;
  localparam int TRIP_VOLT = 1;
  localparam int TRIP_CURR = 2;
  localparam int TRIP_HOT = 3;
  localparam int TRIP_COLD = 4;
  localparam int TRIP_PWR = 5;
  localparam int N_MON = 5;
  localparam logic [15:0] TRIP_MASK = 16'h003f;
  // ==========================================================
  // Diagnostic register fields
  localparam int DIAG_LOWVCC = 11;
  localparam int DIAG_WDOG = 13;
  localparam int DIAG_INRUSH = 14;
  localparam logic [15:0] DIAG_MASK = 16'h6800;
  // ==========================================================
  // Control register, interrupt and status fields
  localparam int CTRL_TRIP_RESET = 0;
  localparam int CTRL_WARN_CLEAR = 1;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_INRUSH = 1;
  localparam int IRQ_WDOG = 2;
  localparam int IRQ_LOWVCC = 3;
  localparam int N_IRQ = 4;
  localparam int ST_WARN = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_NVM_BLOCK = 2;
  localparam int DOUT_RELAY = 0;
  // ==========================================================
  // Synchronised input positions
  localparam int SI_SPEED_N = 0;
  localparam int SI_VOLT_N = 1;
  localparam int SI_CURR_N = 2;
  localparam int SI_HOT_N = 3;
  localparam int SI_COLD_N = 4;
  localparam int SI_PWR = 5;
  localparam int SI_BYPASS = 6;
  localparam int SI_RELAY_OPEN = 7;
  localparam int SI_RELAY_DRV = 8;
  localparam int SI_START = 9;
  localparam int SI_WDOG = 10;
  localparam int SI_LOWVCC = 11;
  localparam int N_SYNC = 12;
  // Monitors idle high so they reset high and raise no trip
  localparam logic [N_SYNC-1:0] SYNC_RST = 12'h01f;
  // ==========================================================
  // Reset values
  localparam logic [15:0] TRIP_RST = 16'h0000;
  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [N_IRQ-1:0] IRQ_RST = 4'h0;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int WARN_DELAY_US = 10;
  localparam int WARN_DELAY_CYC = WARN_DELAY_US * CLK_MHZ;
  localparam int WDOG_HOLD_US = 1;
  localparam int WDOG_HOLD_CYC = WDOG_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 12;
  // ==========================================================
  typedef enum logic [1:0] {WD_IDLE, WD_LOG, WD_HOLD, WD_RESTART} dts_wd_state_t;
endpackage
`default_nettype wire

// [rtl/dts_sync.sv]
// Two-flop synchroniser bank for the asynchronous monitor pins
`default_nettype none
module dts_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins
  input wire logic [dts_pkg::N_SYNC-1:0] raw,
  // Synchronised levels
  dts_mon_if.src mon
);
  logic [dts_pkg::N_SYNC-1:0] meta_r;
  logic [dts_pkg::N_SYNC-1:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < dts_pkg::N_SYNC; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[g] <= dts_pkg::SYNC_RST[g];
          sync_r[g] <= dts_pkg::SYNC_RST[g];
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign mon.level = sync_r;
endmodule
`default_nettype wire
